// >>> include/lebank_pkg.sv
/*
 lebank_pkg: register indices, reset values, field positions and carrier
 types for the limit and user-word register bank.
 Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
*/
package lebank_pkg;
    // printed offsets are register indices; byte address is index times four
    localparam logic [3:0] LEB_IDX_CFG_REG = 4'h1;
    localparam logic [3:0] LEB_IDX_UB1 = 4'h2;
    localparam logic [3:0] LEB_IDX_LB1 = 4'h3;
    localparam logic [3:0] LEB_IDX_UB2 = 4'h4;
    localparam logic [3:0] LEB_IDX_LB2 = 4'h5;
    localparam logic [3:0] LEB_IDX_NV_FIRST = 4'h6;
    localparam logic [3:0] LEB_IDX_NV_LAST = 4'hD;
    localparam logic [3:0] LEB_IDX_ID = 4'hF;
    // block's own registers, above the printed map
    localparam logic [4:0] LEB_IDX_CTRL = 5'h10;
    localparam logic [4:0] LEB_IDX_RESULT = 5'h11;
    localparam logic [4:0] LEB_IDX_IRQ_STAT = 5'h12;
    localparam logic [4:0] LEB_IDX_IRQ_MASK = 5'h13;
    localparam int LEB_NV_WORDS = 8;
    localparam logic [15:0] LEB_UB_RESET = 16'h7FFC;
    localparam logic [15:0] LEB_LB_RESET = 16'h8000;
    localparam logic [15:0] LEB_NV_RESET = 16'h0000;
    localparam logic [15:0] LEB_LIMIT_MASK = 16'hFFFC;
    // identity value is arbitrary
    localparam logic [15:0] LEB_IDENTITY = 16'hA5C3;
    localparam int LEB_CTRL_UNLOCK_BIT = 0;
    localparam int LEB_CTRL_THERM_BIT = 1;
    localparam int LEB_RES_DONE_BIT = 16;
    localparam int LEB_FLAG_OVER_BIT = 0;
    localparam int LEB_FLAG_UNDER_BIT = 1;
    localparam int LEB_IRQ_OVER_BIT = 0;
    localparam int LEB_IRQ_UNDER_BIT = 1;
    localparam int LEB_IRQ_LOCKED_BIT = 2;
    localparam logic [1:0] LEB_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] LEB_HTRANS_SEQ = 2'h3;

    typedef struct packed {
        logic [15:0] upper_bound_one;
        logic [15:0] lower_bound_one;
        logic [15:0] upper_bound_two;
        logic [15:0] lower_bound_two;
    } leb_limits_s;

    typedef struct packed {
        logic over_limit_flag_two;
        logic under_limit_flag_two;
    } leb_flags_s;
endpackage : lebank_pkg

// >>> hdl/lebank_alert_two.sv
/*
 lebank_alert_two: flag logic for alert function 2, window or thermostat.
 Assumes one-cycle conversion-done pulse with a signed result word.
*/
`timescale 1ns/1ps
module lebank_alert_two
    import lebank_pkg::*;
(
    input wire logic hclk, // clock
    input wire logic hresetn, // async reset, low
    input wire logic therm_mode, // 1 thermostat, 0 window
    input wire logic conv_done, // result valid pulse
    input wire logic [15:0] result, // conversion result
    input wire logic [15:0] upper_bound_two, // upper threshold
    input wire logic [15:0] lower_bound_two, // lower threshold
    input wire logic cfg_read, // config read pulse
    output leb_flags_s flags // flags, registered
);
    leb_flags_s flags_reg;
    leb_flags_s flags_next;
    wire logic above = $signed(result) > $signed(upper_bound_two);
    wire logic below = $signed(result) < $signed(lower_bound_two);

    always_comb begin
        flags_next = flags_reg;
        if (therm_mode) begin
            // hysteresis: only a new result moves the flag
            if (conv_done && above)
                flags_next.over_limit_flag_two = 1'b1; // RL14
            else if (conv_done && below)
                flags_next.over_limit_flag_two = 1'b0; // RL14
            flags_next.under_limit_flag_two = 1'b0; // RL14
        end else begin
            // a crossing in the clear cycle wins over the read
            if (cfg_read) begin
                flags_next.over_limit_flag_two = 1'b0; // RL13
                flags_next.under_limit_flag_two = 1'b0; // RL13
            end
            if (conv_done && above)
                flags_next.over_limit_flag_two = 1'b1; // RL7 RL13
            if (conv_done && below)
                flags_next.under_limit_flag_two = 1'b1; // RL13
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            flags_reg <= '0;
        else
            flags_reg <= flags_next;
    end
    assign flags = flags_reg;

    property p_therm_set;
        @(posedge hclk) disable iff (!hresetn)
        (therm_mode && conv_done && above) |=> flags.over_limit_flag_two;
    endproperty
    a_therm_set: assert property (p_therm_set) // RL14
        else $error("thermostat flag not set above limit");

    property p_therm_hold;
        @(posedge hclk) disable iff (!hresetn)
        (therm_mode && $past(therm_mode) && !$past(conv_done))
            |-> $stable(flags.over_limit_flag_two);
    endproperty
    a_therm_hold: assert property (p_therm_hold) // RL14
        else $error("thermostat flag moved without conversion");

    property p_win_clear;
        @(posedge hclk) disable iff (!hresetn)
        (!therm_mode && cfg_read && !conv_done)
            |=> !flags.over_limit_flag_two && !flags.under_limit_flag_two;
    endproperty
    a_win_clear: assert property (p_win_clear) // RL13
        else $error("window flags not cleared by config read");

    property p_win_low;
        @(posedge hclk) disable iff (!hresetn)
        (!therm_mode && conv_done && below) |=> flags.under_limit_flag_two;
    endproperty
    a_win_low: assert property (p_win_low) // RL13
        else $error("under flag not set below limit");
endmodule : lebank_alert_two

// >>> hdl/lebank_top.sv
/*
 lebank_top: limit and user-word register bank behind an AHB-Lite slave.
 Assumes single-word transfers, one master, and a conversion pulse from
 the measurement core; all inputs synchronous to hclk.
*/
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps
// What this block does
// RL1 - first upper threshold at index 2h, resets to 7FFCh
// RL2 - thresholds hold signed 14-bit value in bits 15-2, read/write
// RL3 - first lower threshold at index 3h, resets to 8000h
// RL4 - second upper threshold at index 4h, resets to 7FFCh
// RL5 - second lower threshold at index 5h, resets to 8000h
// RL6 - first lower threshold bounds alert one, paired with first upper
// RL7 - second upper threshold bounds alert two, paired with second lower
// RL8 - eight 16-bit user words at 6h to Dh, read/write, reset zero
// RL9 - user word writes accepted only while unlock bit is one
// RL10 - with unlock bit zero, user word writes are discarded
// RL11 - read-only identity word at index Fh
// RL12 - threshold bits 1 and 0 read zero, writes ignored
// RL13 - window mode sets over/under flags, config read clears them
// RL14 - thermostat mode: over flag set above, released below; under zero
module lebank_top
    import lebank_pkg::*;
(
    input wire logic hclk, // bus clock
    input wire logic hresetn, // async reset, low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write
    input wire logic [2:0] hsize, // size, word only
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    input wire logic conv_done, // conversion done pulse
    input wire logic [15:0] conv_result, // conversion result
    output logic [31:0] hrdata, // read data, registered
    output logic hreadyout, // low for the one wait cycle of each read
    output logic hresp, // always OKAY
    output logic alert_one, // alert one level, registered
    output leb_flags_s alert_two_flags, // alert two flags
    output logic irq // interrupt, registered
);
    leb_limits_s limits_reg;
    logic [15:0] nv_reg [LEB_NV_WORDS];
    logic [1:0] ctrl_reg;
    logic [15:0] result_reg;
    logic [2:0] stat_reg;
    logic [2:0] mask_reg;
    logic wr_pend_reg;
    logic rd_pend_reg;
    logic [4:0] idx_reg;
    logic [31:0] hrdata_reg;
    logic alert_one_reg;
    logic irq_reg;
    logic ready_reg;
    leb_flags_s flags;
    leb_flags_s flags_d_reg;

    function automatic logic [15:0] limit_field(input logic [31:0] d);
        return d[15:0] & LEB_LIMIT_MASK; // RL2 RL12
    endfunction : limit_field

    wire logic addr_ok = haddr[31:7] == 25'h0 && haddr[1:0] == 2'h0;
    wire logic xfer = hsel && hready && (htrans == LEB_HTRANS_NONSEQ ||
        htrans == LEB_HTRANS_SEQ);
    wire logic [4:0] a_idx = haddr[6:2];
    wire logic wr_go = wr_pend_reg;
    wire logic in_nv = idx_reg >= {1'b0, LEB_IDX_NV_FIRST} &&
        idx_reg <= {1'b0, LEB_IDX_NV_LAST};
    wire logic [2:0] nv_sel = 3'(idx_reg - {1'b0, LEB_IDX_NV_FIRST});
    wire logic unlocked = ctrl_reg[LEB_CTRL_UNLOCK_BIT];
    wire logic nv_wr_ok = wr_go && in_nv && unlocked; // RL9
    wire logic nv_wr_lock = wr_go && in_nv && !unlocked; // RL10
    wire logic rd_take = xfer && !hwrite && addr_ok;
    // flags clear as the read is answered, so the read still shows them
    wire logic cfg_read = rd_pend_reg &&
        idx_reg == {1'b0, LEB_IDX_CFG_REG};
    wire logic rd_nv = in_nv;
    wire logic [15:0] nv_rd = nv_reg[nv_sel];
    wire logic [2:0] ev = {nv_wr_lock,
        flags.under_limit_flag_two & ~flags_d_reg.under_limit_flag_two,
        flags.over_limit_flag_two & ~flags_d_reg.over_limit_flag_two};
    wire logic [2:0] w1c = (wr_go && idx_reg == LEB_IDX_IRQ_STAT) ?
        hwdata[2:0] : 3'h0;
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0;
        if (rd_pend_reg) begin
            unique case (1'b1)
                idx_reg == {1'b0, LEB_IDX_UB1}:
                    rd_mux = {16'h0, limits_reg.upper_bound_one};
                idx_reg == {1'b0, LEB_IDX_LB1}:
                    rd_mux = {16'h0, limits_reg.lower_bound_one};
                idx_reg == {1'b0, LEB_IDX_UB2}:
                    rd_mux = {16'h0, limits_reg.upper_bound_two};
                idx_reg == {1'b0, LEB_IDX_LB2}:
                    rd_mux = {16'h0, limits_reg.lower_bound_two};
                rd_nv: rd_mux = {16'h0, nv_rd}; // RL8
                idx_reg == {1'b0, LEB_IDX_CFG_REG}:
                    rd_mux = {30'h0, flags};
                idx_reg == {1'b0, LEB_IDX_ID}:
                    rd_mux = {16'h0, LEB_IDENTITY}; // RL11
                idx_reg == LEB_IDX_CTRL: rd_mux = {30'h0, ctrl_reg};
                idx_reg == LEB_IDX_RESULT:
                    rd_mux = {16'h0, result_reg};
                idx_reg == LEB_IDX_IRQ_STAT: rd_mux = {29'h0, stat_reg};
                idx_reg == LEB_IDX_IRQ_MASK: rd_mux = {29'h0, mask_reg};
                default: rd_mux = 32'h0;
            endcase
        end
    end

    // reads take one wait state: hrdata stays a flop and still sees a
    // write that landed at the read's own address edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            ready_reg <= 1'b1;
            idx_reg <= 5'h0;
        end else begin
            wr_pend_reg <= xfer && hwrite && addr_ok;
            rd_pend_reg <= rd_take;
            ready_reg <= !rd_take;
            idx_reg <= a_idx;
        end
    end

    // loaded at the end of the wait cycle, zero when no read is pending
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            hrdata_reg <= 32'h0;
        else
            hrdata_reg <= rd_mux;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            limits_reg.upper_bound_one <= LEB_UB_RESET; // RL1
            limits_reg.lower_bound_one <= LEB_LB_RESET; // RL3
            limits_reg.upper_bound_two <= LEB_UB_RESET; // RL4
            limits_reg.lower_bound_two <= LEB_LB_RESET; // RL5
        end else if (wr_go) begin
            if (idx_reg == {1'b0, LEB_IDX_UB1})
                limits_reg.upper_bound_one <= limit_field(hwdata); // RL1
            if (idx_reg == {1'b0, LEB_IDX_LB1})
                limits_reg.lower_bound_one <= limit_field(hwdata); // RL3
            if (idx_reg == {1'b0, LEB_IDX_UB2})
                limits_reg.upper_bound_two <= limit_field(hwdata); // RL4
            if (idx_reg == {1'b0, LEB_IDX_LB2})
                limits_reg.lower_bound_two <= limit_field(hwdata); // RL5
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < LEB_NV_WORDS; i++)
                nv_reg[i] <= LEB_NV_RESET; // RL8
        end else if (nv_wr_ok) begin
            nv_reg[nv_sel] <= hwdata[15:0]; // RL9
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= 2'h0;
            mask_reg <= 3'h0;
            result_reg <= 16'h0;
        end else begin
            if (wr_go && idx_reg == LEB_IDX_CTRL)
                ctrl_reg <= hwdata[1:0];
            if (wr_go && idx_reg == LEB_IDX_IRQ_MASK)
                mask_reg <= hwdata[2:0];
            if (conv_done)
                result_reg <= conv_result;
        end
    end

    // set wins over a same-cycle write-one clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_reg <= 3'h0;
            flags_d_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            stat_reg <= (stat_reg & ~w1c) | ev;
            flags_d_reg <= flags;
            irq_reg <= |(((stat_reg & ~w1c) | ev) & mask_reg);
        end
    end

    // alert one: level outside window of the first pair
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            alert_one_reg <= 1'b0;
        else if (conv_done)
            alert_one_reg <= $signed(conv_result) >
                $signed(limits_reg.upper_bound_one) ||
                $signed(conv_result) <
                $signed(limits_reg.lower_bound_one); // RL6
    end

    lebank_alert_two u_alert_two (
        .hclk(hclk),
        .hresetn(hresetn),
        .therm_mode(ctrl_reg[LEB_CTRL_THERM_BIT]),
        .conv_done(conv_done),
        .result(conv_result),
        .upper_bound_two(limits_reg.upper_bound_two), // RL7
        .lower_bound_two(limits_reg.lower_bound_two),
        .cfg_read(cfg_read),
        .flags(flags)
    );

    assign hrdata = hrdata_reg;
    assign hreadyout = ready_reg;
    assign hresp = 1'b0;
    assign alert_one = alert_one_reg;
    assign alert_two_flags = flags;
    assign irq = irq_reg;

    property p_limit_lsbs;
        @(posedge hclk) disable iff (!hresetn)
        limits_reg.upper_bound_one[1:0] == 2'h0 &&
        limits_reg.lower_bound_one[1:0] == 2'h0 &&
        limits_reg.upper_bound_two[1:0] == 2'h0 &&
        limits_reg.lower_bound_two[1:0] == 2'h0;
    endproperty
    a_limit_lsbs: assert property (p_limit_lsbs) // RL12
        else $error("threshold reserved bits nonzero");

    property p_ub1_write;
        @(posedge hclk) disable iff (!hresetn)
        (wr_go && idx_reg == {1'b0, LEB_IDX_UB1}) |=>
            limits_reg.upper_bound_one == ($past(hwdata[15:0]) & 16'hFFFC);
    endproperty
    a_ub1_write: assert property (p_ub1_write) // RL2
        else $error("upper threshold one not written");

    property p_nv_locked;
        @(posedge hclk) disable iff (!hresetn)
        nv_wr_lock |=> nv_reg[$past(nv_sel)] == $past(nv_rd);
    endproperty
    a_nv_locked: assert property (p_nv_locked) // RL10
        else $error("locked user word changed");

    property p_nv_open;
        @(posedge hclk) disable iff (!hresetn)
        nv_wr_ok |=> nv_reg[$past(nv_sel)] == $past(hwdata[15:0]);
    endproperty
    a_nv_open: assert property (p_nv_open) // RL9
        else $error("unlocked user word write lost");

    property p_id_read;
        @(posedge hclk) disable iff (!hresetn)
        (rd_pend_reg && idx_reg == {1'b0, LEB_IDX_ID}) |=>
            hrdata == {16'h0, LEB_IDENTITY};
    endproperty
    a_id_read: assert property (p_id_read) // RL11
        else $error("identity read wrong");

    property p_lb1_write;
        @(posedge hclk) disable iff (!hresetn)
        (wr_go && idx_reg == {1'b0, LEB_IDX_LB1}) |=>
            limits_reg.lower_bound_one == limit_field($past(hwdata));
    endproperty
    a_lb1_write: assert property (p_lb1_write) // RL3
        else $error("lower threshold one not written");

    property p_ub2_write;
        @(posedge hclk) disable iff (!hresetn)
        (wr_go && idx_reg == {1'b0, LEB_IDX_UB2}) |=>
            limits_reg.upper_bound_two == limit_field($past(hwdata));
    endproperty
    a_ub2_write: assert property (p_ub2_write) // RL4
        else $error("upper threshold two not written");

    property p_lb2_write;
        @(posedge hclk) disable iff (!hresetn)
        (wr_go && idx_reg == {1'b0, LEB_IDX_LB2}) |=>
            limits_reg.lower_bound_two == limit_field($past(hwdata));
    endproperty
    a_lb2_write: assert property (p_lb2_write) // RL5
        else $error("lower threshold two not written");

    property p_limits_hold;
        @(posedge hclk) disable iff (!hresetn)
        !wr_go |=> $stable(limits_reg);
    endproperty
    a_limits_hold: assert property (p_limits_hold) // RL2
        else $error("threshold changed without a write");

    property p_lock_sets;
        @(posedge hclk) disable iff (!hresetn)
        nv_wr_lock |=> stat_reg[LEB_IRQ_LOCKED_BIT];
    endproperty
    a_lock_sets: assert property (p_lock_sets) // RL10
        else $error("discarded user word write not flagged");

    sequence s_id_request;
        rd_take && a_idx == {1'b0, LEB_IDX_ID};
    endsequence

    sequence s_id_answer;
        !hreadyout ##1 (hreadyout && hrdata == {16'h0, LEB_IDENTITY});
    endsequence

    property p_id_answer;
        @(posedge hclk) disable iff (!hresetn)
        s_id_request |=> s_id_answer;
    endproperty
    a_id_answer: assert property (p_id_answer) // RL11
        else $error("identity read not answered after one wait");

    property p_alert_one_on;
        @(posedge hclk) disable iff (!hresetn)
        (conv_done &&
            $signed(conv_result) > $signed(limits_reg.upper_bound_one))
            |=> alert_one;
    endproperty
    a_alert_one_on: assert property (p_alert_one_on) // RL6
        else $error("alert one missed upper crossing");

    property p_alert_one_hold;
        @(posedge hclk) disable iff (!hresetn)
        !conv_done |=> $stable(alert_one);
    endproperty
    a_alert_one_hold: assert property (p_alert_one_hold) // RL6
        else $error("alert one moved without conversion");

    property p_cfg_read_data;
        @(posedge hclk) disable iff (!hresetn)
        (rd_pend_reg && idx_reg == {1'b0, LEB_IDX_CFG_REG}) |=>
            hrdata == {30'h0, $past(flags)};
    endproperty
    a_cfg_read_data: assert property (p_cfg_read_data) // RL13
        else $error("config read lost the flags");

    property p_ub2_alert;
        @(posedge hclk) disable iff (!hresetn)
        (conv_done &&
            $signed(conv_result) > $signed(limits_reg.upper_bound_two))
            |=> alert_two_flags.over_limit_flag_two;
    endproperty
    a_ub2_alert: assert property (p_ub2_alert) // RL7
        else $error("upper threshold two crossing missed");
endmodule : lebank_top

// >>> verification/lebank_host_model.sv
/*
 lebank_host_model: AHB-Lite master standing in for the host controller.
 Assumes one slave whose hreadyout comes back as hready, and callers that
 enter xfer just after a rising edge of hclk.
*/
`timescale 1ns/1ps
module lebank_host_model
    import lebank_pkg::*;
(
    input wire logic hclk, // bus clock
    input wire logic hready, // slave ready
    output logic hsel, // slave select
    output logic [31:0] haddr, // byte address
    output logic [1:0] htrans, // transfer type
    output logic hwrite, // write
    output logic [2:0] hsize, // always one word
    output logic [31:0] hwdata // write data
);
    initial begin
        hsel = 1'h0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end

    // one single word transfer; the master never assumes a wait count
    task automatic xfer(input logic wr, input logic [31:0] a,
                        input logic [31:0] d);
        hsel <= 1'h1;
        haddr <= a;
        htrans <= LEB_HTRANS_NONSEQ;
        hwrite <= wr;
        hsize <= 3'h2;
        @(posedge hclk);
        while (hready !== 1'h1) @(posedge hclk);
        hsel <= 1'h0;
        htrans <= 2'h0;
        haddr <= ~a;
        hwdata <= wr ? d : ~hwdata;
        @(posedge hclk);
        while (hready !== 1'h1) @(posedge hclk);
        // released data must not look like the last value
        hwdata <= ~d;
    endtask : xfer
endmodule : lebank_host_model

// >>> verification/limit_eeprom_register_bank_tb.sv
/*
 limit_eeprom_register_bank_tb: self-checking bench for lebank_top.
 Assumes the host model as bus master; a read answers after one wait
 state and its word is taken at the edge that ends the data phase.
 The bench plays the conversion core.
*/
`timescale 1ns/1ps
module limit_eeprom_register_bank_tb
    import lebank_pkg::*;
;
    logic hclk = 1'h0;
    logic hresetn = 1'h0;
    logic conv_done = 1'h0;
    logic [15:0] conv_result = 16'h0;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic alert_one;
    leb_flags_s alert_two_flags;
    logic irq;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    logic [32:0] exp_q[$];
    logic [32:0] note;
    logic rd_ph;
    logic [15:0] val[8];

    always #20 hclk = ~hclk;

    lebank_host_model host (.hclk(hclk), .hready(hready), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata));

    lebank_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .conv_done(conv_done),
        .conv_result(conv_result), .hrdata(hrdata), .hreadyout(hready),
        .hresp(hresp), .alert_one(alert_one),
        .alert_two_flags(alert_two_flags), .irq(irq));

    task automatic compare_word(input logic [31:0] got, input logic [31:0] e);
        check_count++;
        if (got !== e) begin
            miscompares++;
            $display("BAD %0t read %h expected %h", $time, got, e);
        end
    endtask : compare_word

    task automatic compare_pins(input logic [3:0] got, input logic [3:0] e);
        check_count++;
        if (got !== e) begin
            miscompares++;
            $display("BAD %0t pins %h expected %h", $time, got, e);
        end
    endtask : compare_pins

    task automatic tally_and_finish();
        if (miscompares == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // a read word stands in its data phase until hready is sampled high
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_ph <= 1'h0;
        end else if (hready) begin
            if (rd_ph) begin
                note = exp_q.pop_front();
                if (note[32]) compare_word(hrdata, note[31:0]);
                compare_word({31'h0, hresp}, 32'h0);
            end
            rd_ph <= hsel && !hwrite && htrans == LEB_HTRANS_NONSEQ;
        end
    end

    always @(posedge hclk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    function automatic logic [31:0] ba(input logic [4:0] idx);
        return {25'h0, idx, 2'h0};
    endfunction : ba

    function automatic logic [15:0] rst_val(input logic [3:0] i);
        if (i == LEB_IDX_UB1 || i == LEB_IDX_UB2) return LEB_UB_RESET;
        if (i == LEB_IDX_LB1 || i == LEB_IDX_LB2) return LEB_LB_RESET;
        if (i == LEB_IDX_ID) return LEB_IDENTITY;
        return LEB_NV_RESET;
    endfunction : rst_val

    task automatic wr(input logic [4:0] idx, input logic [31:0] d);
        host.xfer(1'h1, ba(idx), d);
    endtask : wr

    // chk low: read only for its side effect
    task automatic rd(input logic [4:0] idx, input logic chk,
                      input logic [31:0] e);
        exp_q.push_back({chk, e});
        host.xfer(1'h0, ba(idx), 32'h0);
    endtask : rd

    task automatic conv(input logic [15:0] v);
        conv_done <= 1'h1;
        conv_result <= v;
        @(posedge hclk);
        conv_done <= 1'h0;
        conv_result <= ~v;
    endtask : conv

    // e is {alert_one, over flag, under flag, irq}
    task automatic pins(input logic [3:0] e);
        repeat (3) @(posedge hclk);
        @(negedge hclk);
        compare_pins({alert_one, alert_two_flags, irq}, e);
        @(posedge hclk);
    endtask : pins

    initial begin
        void'($urandom(32'hF5E06808));
        repeat (12) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        for (int i = 2; i < 16; i++) begin
            rd(5'(i), 1'h1, {16'h0, rst_val(4'(i))});
        end
        rd(5'h14, 1'h1, 32'h0);
        for (int k = 0; k < 4; k++) begin
            val[k] = 16'($urandom);
            wr(5'(2 + k), {16'($urandom), val[k]});
        end
        for (int k = 0; k < 4; k++) begin
            rd(5'(2 + k), 1'h1, {16'h0, val[k] & LEB_LIMIT_MASK});
        end
        wr(5'(LEB_IDX_ID), 32'h0000FFFF);
        rd(5'(LEB_IDX_ID), 1'h1, {16'h0, LEB_IDENTITY});
        wr(LEB_IDX_IRQ_MASK, 32'h0);
        for (int k = 0; k < 8; k++) wr(5'(LEB_IDX_NV_FIRST + k), $urandom);
        for (int k = 0; k < 8; k++) begin
            rd(5'(LEB_IDX_NV_FIRST + k), 1'h1, 32'h0);
        end
        rd(LEB_IDX_IRQ_STAT, 1'h1, 32'h4);
        pins(4'h0);
        wr(LEB_IDX_IRQ_MASK, 32'h4);
        pins(4'h1);
        wr(LEB_IDX_IRQ_STAT, 32'h4);
        pins(4'h0);
        wr(LEB_IDX_CTRL, 32'h1);
        for (int k = 0; k < 8; k++) begin
            val[k] = 16'($urandom);
            wr(5'(LEB_IDX_NV_FIRST + k), {16'h0, val[k]});
        end
        for (int k = 0; k < 8; k++) begin
            rd(5'(LEB_IDX_NV_FIRST + k), 1'h1, {16'h0, val[k]});
        end
        rd(LEB_IDX_IRQ_STAT, 1'h1, 32'h0);
        wr(LEB_IDX_CTRL, 32'h0);
        wr(5'(LEB_IDX_NV_FIRST), {16'h0, ~val[0]});
        rd(5'(LEB_IDX_NV_FIRST), 1'h1, {16'h0, val[0]});
        wr(LEB_IDX_IRQ_STAT, 32'h4);
        wr(5'(LEB_IDX_UB1), 32'h0400);
        wr(5'(LEB_IDX_LB1), 32'hFC00);
        wr(5'(LEB_IDX_UB2), 32'h0800);
        wr(5'(LEB_IDX_LB2), 32'hF800);
        wr(LEB_IDX_IRQ_MASK, 32'h3);
        conv(16'h0800);
        pins(4'h8);
        conv(16'h0900);
        pins(4'hD);
        conv(16'h0000);
        pins(4'h5);
        rd(5'(LEB_IDX_CFG_REG), 1'h1, 32'h2);
        pins(4'h1);
        wr(LEB_IDX_IRQ_STAT, 32'h1);
        pins(4'h0);
        conv(16'hF000);
        pins(4'hB);
        rd(5'(LEB_IDX_CFG_REG), 1'h1, 32'h1);
        pins(4'h9);
        wr(LEB_IDX_IRQ_STAT, 32'h3);
        wr(LEB_IDX_IRQ_MASK, 32'h0);
        pins(4'h8);
        wr(LEB_IDX_CTRL, 32'h2);
        conv(16'h0900);
        pins(4'hC);
        conv(16'h0000);
        pins(4'h4);
        rd(5'(LEB_IDX_CFG_REG), 1'h1, 32'h2);
        pins(4'h4);
        conv(16'hF800);
        pins(4'hC);
        conv(16'hF000);
        pins(4'h8);
        repeat (4) @(posedge hclk);
        tally_and_finish();
    end
endmodule : limit_eeprom_register_bank_tb
